// file: rtl/cpca_ctrl_regs.sv
/*
   control register bank of a stereo codec: power, clocks, routing,
   interface format, level-control timers; assumes a host on the
   three-wire port and a frame clock pin in the ref_clk domain
*/
`timescale 1ns/10ps
`default_nettype none
`include "cpca_cfg.svh"
module cpca_ctrl_regs
   import cpca_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hwPowerDownPin_n,
   input wire logic cpuSelect_n,
   input wire logic cpuClk,
   input wire logic cpuDataIn,
   output logic cpuDataOut,
   input wire logic frameClockPin,
   input wire logic alcGainPending,
   input wire logic alcOverFullScale,
   input wire logic alcZeroCross,
   output logic alcGainApply,
   output cpca_power_t blockPower,
   output cpca_clock_t clockCfg,
   output cpca_route_t routeCfg,
   output cpca_level_t levelCfg,
   output logic allPowerDown,
   output logic adcDataEnable,
   output logic serialDataOutForceLow,
   output logic lineOutToGround,
   output logic speakerPosPinOe_n,
   output logic speakerNegPinMid,
   output logic masterClockOutPin
);
   localparam int N = `CPCA_NUM_REGS;
   localparam logic [6:0] REG_ADDR [N] = '{`CPCA_OFS_PWR1, `CPCA_OFS_PWR2, `CPCA_OFS_RTA,
      `CPCA_OFS_RTB, `CPCA_OFS_IFM, `CPCA_OFS_RATE, `CPCA_OFS_TMR, `CPCA_OFS_LCA,
      `CPCA_OFS_LREF, `CPCA_OFS_LCC, `CPCA_OFS_PWR3};
   localparam logic [7:0] REG_MASK [N] = '{`CPCA_MSK_PWR1, `CPCA_MSK_PWR2, `CPCA_MSK_RTA,
      `CPCA_MSK_RTB, `CPCA_MSK_IFM, `CPCA_MSK_RATE, `CPCA_MSK_TMR, `CPCA_MSK_LCA,
      `CPCA_MSK_LREF, `CPCA_MSK_LCC, `CPCA_MSK_PWR3};
   localparam logic [7:0] REG_RST [N] = '{`CPCA_RST_PWR1, `CPCA_RST_PWR2, `CPCA_RST_RTA,
      `CPCA_RST_RTB, `CPCA_RST_IFM, `CPCA_RST_RATE, `CPCA_RST_TMR, `CPCA_RST_LCA,
      `CPCA_RST_LREF, `CPCA_RST_LCC, `CPCA_RST_PWR3};

   cpca_wr_t wrReq;
   logic [6:0] rdAddr;
   logic [7:0] rdData;
   logic [7:0] regs_q [N];
   logic [7:0] pwr1, pwr2, rta, rtb, ifm, rate, tmr, lca, lref, lcc, pwr3;
   logic adcOn, adcOnPrev_q, framePrev_q, frameTick;
   logic initBusy, initDone;
   logic pendPrev_q, zcBusy, zcDone;
   logic [10:0] zcLimit;
   logic [3:0] divCnt_q;
   logic spkOn, lineOn;

   cpca_serial_port u_port (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cpuSelect_n(cpuSelect_n),
      .cpuClk(cpuClk),
      .cpuDataIn(cpuDataIn),
      .rdData(rdData),
      .rdAddr(rdAddr),
      .wrReq(wrReq),
      .cpuDataOut(cpuDataOut)
   );

   // pin low holds every register at default, not just at the edge
   for (genvar i = 0; i < N; i++) begin : g_reg
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            regs_q[i] <= REG_RST[i];
         end else if (!hwPowerDownPin_n) begin
            regs_q[i] <= REG_RST[i];
         end else if (wrReq.valid && wrReq.addr == REG_ADDR[i]) begin
            regs_q[i] <= wrReq.data & REG_MASK[i];
         end
      end
   end

   assign pwr1 = regs_q[0];
   assign pwr2 = regs_q[1];
   assign rta = regs_q[2];
   assign rtb = regs_q[3];
   assign ifm = regs_q[4];
   assign rate = regs_q[5];
   assign tmr = regs_q[6];
   assign lca = regs_q[7];
   assign lref = regs_q[8];
   assign lcc = regs_q[9];
   assign pwr3 = regs_q[10];

   // masked bits are stored as zero, so reads need no second mask
   always_comb begin
      rdData = 8'h00;
      for (int i = 0; i < N; i++) begin
         if (rdAddr == REG_ADDR[i]) begin
            rdData = regs_q[i];
         end
      end
   end

   // power: pwr1, pwr2[1:0], rta[2] and pwr3[0] all zero, clock output included, shuts all blocks
   always_comb begin
      allPowerDown = !hwPowerDownPin_n || ((pwr1 & `CPCA_MSK_PWR1) == 8'h00 &&
         (pwr2 & `CPCA_MSK_PWR2 & ~8'h08) == 8'h00 && rta[2] == 1'b0 &&
         (pwr3 & 8'h01) == 8'h00);
   end

   always_comb begin
      blockPower = '0;
      if (!allPowerDown) begin
         blockPower.commonModeRefPower = pwr1[6];
         blockPower.monoInputPower = pwr1[5];
         blockPower.speakerAmpPower = pwr1[4];
         blockPower.lineOutPower = pwr1[3];
         blockPower.dacPower = pwr1[2];
         blockPower.leftAdcPower = pwr1[0];
         blockPower.rightAdcPower = pwr3[0];
         blockPower.micSupplyPower = rta[2];
         blockPower.pllPowerMode = pwr2[0];
      end
   end

   always_comb begin
      clockCfg.masterMode = pwr2[3];
      clockCfg.masterClockOutEnable = pwr2[1];
      clockCfg.clockOutFreqSelect = rate[7:6];
      clockCfg.bitClockOutSelect = ifm[3];
      clockCfg.serialFormatSelect = ifm[1:0];
      clockCfg.pllReferenceSelect = ifm[7:4];
      clockCfg.rateSelect = {rate[5], rate[2:0]};
   end

   assign lineOn = blockPower.lineOutPower;
   assign spkOn = blockPower.speakerAmpPower;

   always_comb begin
      routeCfg.dacToSpeakerSwitch = rta[5];
      routeCfg.monoToSpeakerSwitch = rta[6];
      routeCfg.dacToLineSwitch = rta[4] && lineOn;
      routeCfg.monoToLineSwitch = rtb[2] && lineOn;
      routeCfg.micAmpGain = {rta[1], rtb[5], rta[0]};
      routeCfg.filterPathSelect = rtb[7];
      routeCfg.lineOutPowerSave = rtb[6];
      routeCfg.speakerGain = rtb[4:3];
      routeCfg.lineOutGain = rtb[1:0];
   end

   always_comb begin
      levelCfg.recoveryWaitSelect = {tmr[6], tmr[3:2]};
      levelCfg.zeroCrossTimeoutSelect = tmr[5:4];
      levelCfg.firstRecoverySpeed = tmr[1:0];
      levelCfg.limiterThreshold = {lcc[6], lca[0]};
      levelCfg.recoveryGainStep = {lcc[7], lca[1]};
      levelCfg.limiterAttenStep = lca[3:2];
      levelCfg.limiterZeroCrossDisable = lca[4];
      levelCfg.recordLevelCtrlEnable = lca[5];
      levelCfg.playbackLevelCtrlEnable = lca[6];
      levelCfg.fastLimitEnable = lca[7];
      levelCfg.recoveryReference = lref;
   end

   // pin outputs derived from effective power
   always_comb begin
      lineOutToGround = !lineOn;
      speakerPosPinOe_n = !(spkOn && rta[7]);
      speakerNegPinMid = spkOn && !rta[7];
      serialDataOutForceLow = rtb[7] && blockPower.dacPower;
   end

   // frame clock sampled as a plain synchronous input: one tick per frame
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         framePrev_q <= 1'b0;
         adcOnPrev_q <= 1'b0;
         pendPrev_q <= 1'b0;
      end else begin
         framePrev_q <= frameClockPin;
         adcOnPrev_q <= adcOn;
         pendPrev_q <= alcGainPending;
      end
   end

   assign frameTick = frameClockPin && !framePrev_q;
   assign adcOn = blockPower.leftAdcPower || blockPower.rightAdcPower;

   // restart on each change from both adcs off to either adc on
   cpca_frame_timer #(.W(11)) u_adc_init (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(adcOn && !adcOnPrev_q),
      .clear(!adcOn),
      .tick(frameTick),
      .limit(`CPCA_ADC_INIT_FS),
      .busy(initBusy),
      .done(initDone)
   );

   assign adcDataEnable = adcOn && initDone;

   // zero-cross timeout doubles per select step from the base
   assign zcLimit = `CPCA_ZC_BASE_FS << tmr[5:4];

   cpca_frame_timer #(.W(11)) u_zc_timeout (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(alcGainPending && !pendPrev_q),
      .clear(!alcGainPending),
      .tick(frameTick),
      .limit(zcLimit),
      .busy(zcBusy),
      .done(zcDone)
   );

   always_comb begin
      alcGainApply = alcGainPending && ((lca[7] && alcOverFullScale) ||
         (lca[4] && alcOverFullScale) || alcZeroCross || zcDone);
   end

   // stand-in divider; true rates come from the audio clock tree
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_q <= '0;
      end else begin
         divCnt_q <= divCnt_q + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         masterClockOutPin <= 1'b0;
      end else begin
         masterClockOutPin <= pwr2[1] && hwPowerDownPin_n && divCnt_q[rate[7:6]];
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence adcRise;
      adcOn && !adcOnPrev_q;
   endsequence

   adc_hold_off_a: assert property (adcRise |-> !adcDataEnable [*8])
      else $error("adc data enabled too early");
   adc_data_gate_a: assert property (adcDataEnable |-> adcOn && !initBusy)
      else $error("adc data while initializing");
   pdn_clears_a: assert property (!hwPowerDownPin_n |=> pwr1 == 8'h00 && rta == 8'h01 && lref == 8'hE1)
      else $error("power-down pin did not restore defaults");
   all_down_a: assert property (allPowerDown |-> blockPower == '0)
      else $error("block powered while all down");
   master_clock_out_enable_low_a: assert property (!pwr2[1] |=> !masterClockOutPin)
      else $error("clock out not low when disabled");
   line_ground_a: assert property (!lineOn |-> lineOutToGround && !routeCfg.dacToLineSwitch
      && !routeCfg.monoToLineSwitch)
      else $error("line path active without line power");
   spk_save_a: assert property (spkOn && !rta[7] |-> speakerPosPinOe_n && speakerNegPinMid)
      else $error("speaker power save pins wrong");
   serial_data_output_low_a: assert property (rtb[7] && pwr1[2] && hwPowerDownPin_n |-> serialDataOutForceLow)
      else $error("serial data not forced low");
   ro_zero_a: assert property (pwr1[7] == 1'b0 && pwr1[1] == 1'b0 && pwr2[7:4] == 4'h0
      && ifm[2] == 1'b0 && tmr[7] == 1'b0)
      else $error("read-only bit holds a one");
   write_lands_a: assert property (wrReq.valid && wrReq.addr == `CPCA_OFS_LCA && hwPowerDownPin_n
      |=> lca == $past(wrReq.data))
      else $error("level control write lost");
   fast_limit_a: assert property (alcGainPending && lca[7] && alcOverFullScale |-> alcGainApply)
      else $error("fast limit did not apply at once");

   // a write to the first power register keeps only its power bits
   sequence pwr1Write;
      wrReq.valid && wrReq.addr == `CPCA_OFS_PWR1 && hwPowerDownPin_n;
   endsequence

   sequence alcWaiting;
      alcGainPending && !alcZeroCross && !alcOverFullScale && !zcDone;
   endsequence

   pwr1_store_a: assert property (pwr1Write |=> pwr1 == ($past(wrReq.data) & `CPCA_MSK_PWR1))
      else $error("power register write not masked");
   rtb_store_a: assert property (wrReq.valid && wrReq.addr == `CPCA_OFS_RTB && hwPowerDownPin_n |=>
      routeCfg.micAmpGain[1] == $past(wrReq.data[5]))
      else $error("mic gain middle bit write lost");
   down_retain_a: assert property (allPowerDown && hwPowerDownPin_n && !wrReq.valid |=> $stable(pwr2)
      && $stable(rta) && $stable(lref))
      else $error("registers changed while all down");
   pdn_off_a: assert property (!hwPowerDownPin_n |-> allPowerDown && blockPower == '0)
      else $error("block powered while pin low");
   pdn_master_clock_out_enable_a: assert property (!hwPowerDownPin_n |=> !masterClockOutPin)
      else $error("clock out running while pin low");
   pll_mode_a: assert property (blockPower.pllPowerMode |-> pwr2[0] && !allPowerDown)
      else $error("pll powered without its bit");
   role_default_a: assert property (!hwPowerDownPin_n |=> !clockCfg.masterMode
      && clockCfg.serialFormatSelect == 2'h2 && clockCfg.pllReferenceSelect == 4'h0)
      else $error("clock defaults not restored");
   level_default_a: assert property (!hwPowerDownPin_n |=> levelCfg.recoveryWaitSelect == 3'h0
      && !levelCfg.recordLevelCtrlEnable && !levelCfg.playbackLevelCtrlEnable)
      else $error("level defaults not restored");
   spk_normal_a: assert property (spkOn && rta[7] |-> !speakerPosPinOe_n && !speakerNegPinMid)
      else $error("speaker pins wrong in normal mode");
   line_on_a: assert property (lineOn && rta[4] |-> routeCfg.dacToLineSwitch)
      else $error("line switch blocked with line power");
   alc_wait_a: assert property (alcWaiting |-> !alcGainApply)
      else $error("gain applied before zero cross or timeout");
   alc_timeout_a: assert property (alcGainPending && zcDone |-> alcGainApply)
      else $error("gain not applied at timeout");
   alc_idle_a: assert property (!alcGainPending |-> !alcGainApply)
      else $error("gain applied with nothing pending");
   adc_ready_a: assert property (adcOn && initDone |-> adcDataEnable)
      else $error("adc data held after initialization");
   unmapped_a: assert property (rdAddr == 7'h09 |-> rdData == 8'h00)
      else $error("unmapped address reads nonzero");
endmodule // cpca_ctrl_regs
`default_nettype wire

// file: rtl/cpca_frame_timer.sv
/*
   counts sample-period ticks up to a run-time limit; assumes tick is a
   one-cycle pulse in the ref_clk domain
*/
`timescale 1ns/10ps
`default_nettype none
module cpca_frame_timer
   import cpca_pkg::*;
#(
   parameter int W = 11
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic clear,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic busy,
   output logic done
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (clear) begin
         cnt_q <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         cnt_q <= '0;
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy && tick) begin
         if (cnt_q == limit - W'(1)) begin
            busy <= 1'b0;
            done <= 1'b1;
         end else begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end
endmodule // cpca_frame_timer
`default_nettype wire

// file: rtl/cpca_serial_port.sv
/*
   three-wire control port: 16-bit frames, write flag, 7-bit address,
   8 data bits, msb first; assumes pins synchronous to ref_clk
*/
`timescale 1ns/10ps
`default_nettype none
`include "cpca_cfg.svh"
module cpca_serial_port
   import cpca_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cpuSelect_n,
   input wire logic cpuClk,
   input wire logic cpuDataIn,
   input wire logic [7:0] rdData,
   output logic [6:0] rdAddr,
   output cpca_wr_t wrReq,
   output logic cpuDataOut
);
   logic clkPrev_q;
   logic [4:0] cnt_q;
   logic [14:0] shift_q;
   logic [7:0] out_q;
   logic rise;

   assign rise = cpuClk && !clkPrev_q && !cpuSelect_n;
   assign rdAddr = {shift_q[5:0], cpuDataIn};
   assign cpuDataOut = out_q[7];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkPrev_q <= 1'b0;
      end else begin
         clkPrev_q <= cpuClk;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         shift_q <= '0;
      end else if (cpuSelect_n) begin
         cnt_q <= '0;
      end else if (rise && cnt_q < `CPCA_SER_BITS) begin
         shift_q <= {shift_q[13:0], cpuDataIn};
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // a short frame never commits; an over-long one commits at its sixteenth bit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrReq <= '0;
      end else begin
         wrReq.valid <= rise && cnt_q == `CPCA_SER_LAST && shift_q[14];
         wrReq.addr <= shift_q[13:7];
         wrReq.data <= {shift_q[6:0], cpuDataIn};
      end
   end

   // read data leaves on the rising edges after the address
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= '0;
      end else if (cpuSelect_n) begin
         out_q <= '0;
      end else if (rise && cnt_q == `CPCA_SER_ADDR_BITS && !shift_q[6]) begin
         out_q <= rdData;
      end else if (rise && cnt_q > `CPCA_SER_ADDR_BITS) begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end
endmodule // cpca_serial_port
`default_nettype wire

// file: shared/cpca_cfg.svh
/*
   offsets, write masks, reset values and timing counts of the codec
   control register bank; assumes byte-wide registers and 7-bit addresses
*/
`ifndef CPCA_CFG_SVH
`define CPCA_CFG_SVH

`define CPCA_NUM_REGS 11
`define CPCA_OFS_PWR1 7'h00
`define CPCA_OFS_PWR2 7'h01
`define CPCA_OFS_RTA 7'h02
`define CPCA_OFS_RTB 7'h03
`define CPCA_OFS_IFM 7'h04
`define CPCA_OFS_RATE 7'h05
`define CPCA_OFS_TMR 7'h06
`define CPCA_OFS_LCA 7'h07
`define CPCA_OFS_LREF 7'h08
`define CPCA_OFS_LCC 7'h0B
`define CPCA_OFS_PWR3 7'h10

`define CPCA_MSK_PWR1 8'h7D
`define CPCA_MSK_PWR2 8'h0B
`define CPCA_MSK_RTA 8'hF7
`define CPCA_MSK_RTB 8'hFF
`define CPCA_MSK_IFM 8'hFB
`define CPCA_MSK_RATE 8'hE7
`define CPCA_MSK_TMR 8'h7F
`define CPCA_MSK_LCA 8'hFF
`define CPCA_MSK_LREF 8'hFF
`define CPCA_MSK_LCC 8'hFF
`define CPCA_MSK_PWR3 8'h1F

`define CPCA_RST_PWR1 8'h00
`define CPCA_RST_PWR2 8'h00
`define CPCA_RST_RTA 8'h01
`define CPCA_RST_RTB 8'h00
`define CPCA_RST_IFM 8'h02
`define CPCA_RST_RATE 8'h00
`define CPCA_RST_TMR 8'h00
`define CPCA_RST_LCA 8'h00
`define CPCA_RST_LREF 8'hE1
`define CPCA_RST_LCC 8'h28
`define CPCA_RST_PWR3 8'h00

// adc start-up interval and zero-cross timeout base, in sample periods
`define CPCA_ADC_INIT_FS 11'h423
`define CPCA_ZC_BASE_FS 11'h080
`define CPCA_SER_BITS 5'h10
`define CPCA_SER_ADDR_BITS 5'h07
`define CPCA_SER_LAST 5'h0F

`endif

// file: shared/cpca_pkg.sv
/*
   types of the codec control register bank; assumes cpca_cfg.svh
   carries the numbers
*/
package cpca_pkg;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [7:0] data;
   } cpca_wr_t;

   typedef struct packed {
      logic commonModeRefPower;
      logic monoInputPower;
      logic speakerAmpPower;
      logic lineOutPower;
      logic dacPower;
      logic leftAdcPower;
      logic rightAdcPower;
      logic micSupplyPower;
      logic pllPowerMode;
   } cpca_power_t;

   typedef struct packed {
      logic masterMode;
      logic masterClockOutEnable;
      logic [1:0] clockOutFreqSelect;
      logic bitClockOutSelect;
      logic [1:0] serialFormatSelect;
      logic [3:0] pllReferenceSelect;
      logic [3:0] rateSelect;
   } cpca_clock_t;

   typedef struct packed {
      logic dacToSpeakerSwitch;
      logic monoToSpeakerSwitch;
      logic dacToLineSwitch;
      logic monoToLineSwitch;
      logic [2:0] micAmpGain;
      logic filterPathSelect;
      logic lineOutPowerSave;
      logic [1:0] speakerGain;
      logic [1:0] lineOutGain;
   } cpca_route_t;

   typedef struct packed {
      logic [2:0] recoveryWaitSelect;
      logic [1:0] zeroCrossTimeoutSelect;
      logic [1:0] firstRecoverySpeed;
      logic [1:0] limiterThreshold;
      logic [1:0] recoveryGainStep;
      logic [1:0] limiterAttenStep;
      logic limiterZeroCrossDisable;
      logic recordLevelCtrlEnable;
      logic playbackLevelCtrlEnable;
      logic fastLimitEnable;
      logic [7:0] recoveryReference;
   } cpca_level_t;

endpackage

// file: test/cpca_ctrl_regs_tb.sv
/*
   self-checking bench of the codec control register bank; assumes the
   host model on the control port and a free-running frame clock
*/
`timescale 1ns/10ps
`default_nettype none
module cpca_ctrl_regs_tb
   import cpca_pkg::*;
();
   localparam int NR = 11;
   logic ref_clk, rst_n, hwPowerDownPin_n, cpuSelect_n, cpuClk, cpuDataIn, cpuDataOut;
   logic alcGainPending, alcOverFullScale, alcZeroCross, alcGainApply;
   logic allPowerDown, adcDataEnable, serialDataOutForceLow, lineOutToGround;
   logic speakerPosPinOe_n, speakerNegPinMid, masterClockOutPin;
   wire logic frameClockPin;
   cpca_power_t blockPower;
   cpca_clock_t clockCfg;
   cpca_route_t routeCfg;
   cpca_level_t levelCfg;
   logic [1:0] frameDiv = 2'b00;
   logic [6:0] ofs [NR] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0B, 7'h10};
   logic [7:0] msk [NR] = '{8'h7D, 8'h0B, 8'hF7, 8'hFF, 8'hFB, 8'hE7, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
   logic [7:0] rsv [NR] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'hE1, 8'h28, 8'h00};
   // register value, override/zero-cross/expected apply
   logic [10:0] alcTab [5] = '{{8'h80, 3'b101}, {8'h00, 3'b100}, {8'h00, 3'b011}, {8'h10, 3'b101}, {8'h80, 3'b000}};
   int shadow [NR];
   int nMismatch = 0;
   int cmpCount = 0;

   cpca_ctrl_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .hwPowerDownPin_n(hwPowerDownPin_n),
      .cpuSelect_n(cpuSelect_n), .cpuClk(cpuClk), .cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut),
      .frameClockPin(frameClockPin), .alcGainPending(alcGainPending), .alcOverFullScale(alcOverFullScale),
      .alcZeroCross(alcZeroCross), .alcGainApply(alcGainApply), .blockPower(blockPower),
      .clockCfg(clockCfg), .routeCfg(routeCfg), .levelCfg(levelCfg), .allPowerDown(allPowerDown),
      .adcDataEnable(adcDataEnable), .serialDataOutForceLow(serialDataOutForceLow),
      .lineOutToGround(lineOutToGround), .speakerPosPinOe_n(speakerPosPinOe_n),
      .speakerNegPinMid(speakerNegPinMid), .masterClockOutPin(masterClockOutPin));
   cpca_host_model host (.ref_clk(ref_clk), .cpuDataOut(cpuDataOut), .cpuSelect_n(cpuSelect_n),
      .cpuClk(cpuClk), .cpuDataIn(cpuDataIn));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // frame clock never stops, so converters always see their clocks
   always @(negedge ref_clk) frameDiv <= frameDiv + 2'b01;
   assign frameClockPin = frameDiv[1];

   task automatic finishTest();
      $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input int i, input logic [7:0] d);
      logic [7:0] rd;
      host.frame({1'b1, ofs[i], d}, 16, 0, rd);
      if (hwPowerDownPin_n) shadow[i] = d & msk[i];
      repeat (2) @(negedge ref_clk);
   endtask

   task automatic rdChk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      host.frame({1'b0, a, 8'h00}, 16, $urandom % 3, rd);
      chk("readback", exp, rd);
   endtask

   task automatic checkAll();
      logic [7:0] r [NR];
      logic apd;
      for (int i = 0; i < NR; i++) r[i] = shadow[i][7:0];
      apd = (r[0] == 8'h00) && (r[1][1:0] == 2'b00) && !r[2][2] && !r[10][0];
      for (int i = 0; i < NR; i++) rdChk(ofs[i], r[i]);
      rdChk(7'h09, 8'h00);
      chk("allPowerDown", apd, allPowerDown);
      chk("blockPower", apd ? 9'h000 : {r[0][6:2], r[0][0], r[10][0], r[2][2], r[1][0]}, blockPower);
      chk("clockCfg", {r[1][3], r[1][1], r[5][7:6], r[4][3], r[4][1:0], r[4][7:4], r[5][5], r[5][2:0]},
         clockCfg);
      chk("routeCfg", {r[2][5], r[2][6], r[2][4] & r[0][3], r[3][2] & r[0][3], r[2][1], r[3][5], r[2][0],
         r[3][7:6], r[3][4:3], r[3][1:0]}, routeCfg);
      chk("levelCfg", {r[6][6], r[6][3:2], r[6][5:4], r[6][1:0], r[9][6], r[7][0], r[9][7], r[7][1],
         r[7][3:2], r[7][4], r[7][5], r[7][6], r[7][7], r[8]}, levelCfg);
      chk("lineOutToGround", !r[0][3], lineOutToGround);
      chk("serialDataOutForceLow", r[3][7] & r[0][2], serialDataOutForceLow);
      if (r[0][4]) begin
         chk("speakerPosPinOe_n", !r[2][7], speakerPosPinOe_n);
         chk("speakerNegPinMid", !r[2][7], speakerNegPinMid);
      end
      if (!r[1][1]) chk("masterClockOutPin", 1'b0, masterClockOutPin);
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk);
      nMismatch++;
      finishTest();
   end

   initial begin
      logic [7:0] rd;
      rst_n = 1'b0;
      hwPowerDownPin_n = 1'b1;
      alcGainPending = 1'b0;
      alcOverFullScale = 1'b0;
      alcZeroCross = 1'b0;
      rd = 8'($urandom(57825));
      for (int i = 0; i < NR; i++) shadow[i] = rsv[i];
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      chk("speakerPosPinOe_n", 1'b1, speakerPosPinOe_n);
      checkAll();
      host.frame({1'b1, 7'h09, 8'hFF}, 16, 0, rd);
      repeat (4) begin
         for (int i = 0; i < NR; i++) wr(i, (i == 0) ? 8'($urandom) | 8'h40 : 8'($urandom));
         host.frame({1'b1, ofs[7], 8'h5A}, 10, 0, rd);
         checkAll();
      end
      // playback setup with speaker in both power-save states
      for (int sp = 0; sp < 2; sp++) begin
         wr(0, 8'h74);
         wr(2, {sp[0], 7'h00});
         wr(3, {sp[0], 7'h00});
         checkAll();
      end
      // clear every power bit, common-mode reference last
      wr(10, 8'h00);
      wr(1, 8'h08);
      wr(2, 8'h80);
      wr(0, 8'h00);
      checkAll();
      for (int k = 0; k < 2; k++) begin
         wr(0, 8'h40);
         wr(10, 8'h00);
         if (k == 0) wr(0, 8'h41);
         else wr(10, 8'h01);
         repeat (1057) @(posedge frameClockPin);
         chk("adcDataEnable", 1'b0, adcDataEnable);
         repeat (4) @(posedge frameClockPin);
         @(negedge ref_clk);
         chk("adcDataEnable", 1'b1, adcDataEnable);
      end
      wr(6, 8'h00);
      foreach (alcTab[j]) begin
         wr(7, alcTab[j][10:3]);
         alcOverFullScale = alcTab[j][2];
         alcZeroCross = alcTab[j][1];
         alcGainPending = 1'b1;
         @(negedge ref_clk);
         chk("alcGainApply", alcTab[j][0], alcGainApply);
         alcGainPending = 1'b0;
         alcOverFullScale = 1'b0;
         alcZeroCross = 1'b0;
         @(negedge ref_clk);
      end
      wr(7, 8'h00);
      for (int s = 0; s < 2; s++) begin
         wr(6, 8'(s << 4));
         alcGainPending = 1'b1;
         repeat ((128 << s) - 2) @(posedge frameClockPin);
         chk("alcGainApply", 1'b0, alcGainApply);
         repeat (4) @(posedge frameClockPin);
         chk("alcGainApply", 1'b1, alcGainApply);
         alcGainPending = 1'b0;
         @(negedge ref_clk);
      end
      wr(0, 8'h7D);
      wr(7, 8'hFF);
      hwPowerDownPin_n = 1'b0;
      #5;
      chk("allPowerDown", 1'b1, allPowerDown);
      chk("blockPower", 9'h000, blockPower);
      @(negedge ref_clk);
      wr(7, 8'hAA);
      hwPowerDownPin_n = 1'b1;
      for (int i = 0; i < NR; i++) shadow[i] = rsv[i];
      @(negedge ref_clk);
      checkAll();
      finishTest();
   end
endmodule // cpca_ctrl_regs_tb
`default_nettype wire

// file: test/cpca_host_model.sv
/*
   host side of the three-wire control port: sends 16-bit frames msb first
   and collects read data; assumes the port is sampled by ref_clk
*/
`timescale 1ns/10ps
`default_nettype none
module cpca_host_model (
   input wire logic ref_clk,
   input wire logic cpuDataOut,
   output logic cpuSelect_n,
   output logic cpuClk,
   output logic cpuDataIn
);
   initial begin
      cpuSelect_n = 1'b1;
      cpuClk = 1'b0;
      cpuDataIn = 1'b0;
   end

   // fewer than 16 bits aborts the frame; slow stretches each low phase
   task automatic frame(input logic [15:0] word, input int nBits, input int slow, output logic [7:0] rd);
      rd = 8'h00;
      @(negedge ref_clk);
      cpuSelect_n = 1'b0;
      for (int i = 15; i >= 16 - nBits; i--) begin
         @(negedge ref_clk);
         cpuClk = 1'b0;
         cpuDataIn = word[i];
         repeat (slow) @(negedge ref_clk);
         @(negedge ref_clk);
         // read bit stands until this rise is taken
         if (i < 8) rd[i] = cpuDataOut;
         cpuClk = 1'b1;
      end
      @(negedge ref_clk);
      cpuClk = 1'b0;
      @(negedge ref_clk);
      cpuSelect_n = 1'b1;
      // released line must not keep a stale level
      cpuDataIn = ~cpuDataIn;
   endtask
endmodule // cpca_host_model
`default_nettype wire
